// File: core/gdsl_sense.sv
// Purpose: per-pin level sense evaluation
// Assumes: pin levels synchronous to the clock
// Notes:   code 1 is treated as disabled
`timescale 1ns/10ps
`include "gdsl_params.svh"
module gdsl_sense #(
   parameter int PINS = 32
) (
   input wire logic [PINS-1:0] pin_level,
   input wire logic [2*PINS-1:0] sense_setup,
   output logic [PINS-1:0] sense_hit
);

   // ****************************************
   // level compare
   // ****************************************
   always_comb begin
      for (int i = 0; i < PINS; i++) begin
         case (sense_setup[2*i +: 2])
            `GDSL_SENSE_HIGH: sense_hit[i] = pin_level[i];
            `GDSL_SENSE_LOW: sense_hit[i] = ~pin_level[i];
            default: sense_hit[i] = 1'b0;
         endcase
      end
   end

endmodule

// File: core/gdsl_top.sv
// Purpose: pin direction register with set/clear aliases, sense latch,
//          and two event style selectors behind an AXI4-Lite slave
// Assumes: pins, sense setup and secure map synchronous to core_clk
// Notes:   only rst_n initialises; retention keeps all registers
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
`include "gdsl_params.svh"
module gdsl_top
   import gdsl_pkg::*;
#(
   parameter int PINS = 32,
   parameter int ADDR_W = 12
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [PINS-1:0] pin_level,
   input wire logic [2*PINS-1:0] sense_setup,
   input wire logic [PINS-1:0] pin_secure,
   input wire gdsl_cfg_dir_t cfg_dir_wr,
   output logic [PINS-1:0] pin_dir,
   output logic [PINS-1:0] pin_sense,
   output logic event_nonsecure,
   output logic event_secure,
   output logic irq
);

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [11:0] off);
      hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
   endfunction

   function automatic logic [31:0] strb_mask(input logic [3:0] s);
      strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = hit(a, `GDSL_OFF_DIR) || hit(a, `GDSL_OFF_DIRECTION_SET) ||
         hit(a, `GDSL_OFF_DIRECTION_CLEAR) || hit(a, `GDSL_OFF_LATCH) ||
         hit(a, `GDSL_OFF_MODE_NS) || hit(a, `GDSL_OFF_MODE_SEC) ||
         hit(a, `GDSL_OFF_IRQ_STAT) || hit(a, `GDSL_OFF_IRQ_MASK);
   endfunction

   // ****************************************
   // state
   // ****************************************
   logic [PINS-1:0] dir;
   logic [PINS-1:0] latch;
   logic mode_ns;
   logic mode_sec;
   logic [1:0] irq_stat;
   logic [1:0] irq_mask;
   logic ev_ns_prev;
   logic ev_sec_prev;
   gdsl_wstate_t wstate;
   gdsl_rstate_t rstate;
   gdsl_wreq_t wreq;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic aw_held;
   logic w_held;
   logic wr_do;
   logic [31:0] wr_m;
   logic [31:0] wr_d;
   logic [PINS-1:0] next_dir;
   logic [PINS-1:0] next_latch;
   logic [1:0] ev_rise;
   logic [1:0] stat_clr;
   logic [31:0] rd_val;

   // ****************************************
   // sense evaluation
   // ****************************************
   gdsl_sense #(
      .PINS(PINS)
   ) u_sense (
      .pin_level(pin_level),
      .sense_setup(sense_setup),
      .sense_hit(pin_sense)
   );

   // ****************************************
   // write channel
   // ****************************************
   assign s_axi_awready = (wstate == GDSL_WS_IDLE) && !aw_held;
   assign s_axi_wready = (wstate == GDSL_WS_IDLE) && !w_held;
   assign wr_do = (wstate == GDSL_WS_IDLE) && aw_held && w_held;
   assign wreq = {aw_addr, w_data, w_strb};
   assign wr_m = strb_mask(wreq.strb);
   assign wr_d = wreq.data & wr_m;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_held <= 1'b0;
         aw_addr <= 12'h000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_do) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_do) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wstate <= GDSL_WS_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `GDSL_RESP_OKAY;
      end else begin
         case (wstate)
            GDSL_WS_IDLE: begin
               if (wr_do) begin
                  wstate <= GDSL_WS_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= mapped(wreq.addr) ? `GDSL_RESP_OKAY :
                     `GDSL_RESP_SLVERR;
               end
            end
            default: begin
               if (s_axi_bready) begin
                  wstate <= GDSL_WS_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
            end
         endcase
      end
   end

   // ****************************************
   // direction register, one storage for both views
   // ****************************************
   always_comb begin
      next_dir = dir;
      if (wr_do) begin
         if (hit(wreq.addr, `GDSL_OFF_DIR)) begin
            next_dir = (dir & ~wr_m) | wr_d;
         end else if (hit(wreq.addr, `GDSL_OFF_DIRECTION_SET)) begin
            next_dir = dir | wr_d;
         end else if (hit(wreq.addr, `GDSL_OFF_DIRECTION_CLEAR)) begin
            next_dir = dir & ~wr_d;
         end
      end
      next_dir = (next_dir & ~cfg_dir_wr.en) |
         (cfg_dir_wr.val & cfg_dir_wr.en);
   end

   // retained: only power-on reset clears it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dir <= `GDSL_RST_DIR;
      end else begin
         dir <= next_dir;
      end
   end

   assign pin_dir = dir;

   // ****************************************
   // sense latch, set wins over clear
   // ****************************************
   always_comb begin
      next_latch = latch;
      if (wr_do && hit(wreq.addr, `GDSL_OFF_LATCH)) begin
         next_latch = latch & ~wr_d;
      end
      next_latch = next_latch | pin_sense;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         latch <= `GDSL_RST_LATCH;
      end else begin
         latch <= next_latch;
      end
   end

   // ****************************************
   // event style selectors
   // ****************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_ns <= `GDSL_RST_MODE;
         mode_sec <= `GDSL_RST_MODE;
      end else if (wr_do && wreq.strb[0]) begin
         if (hit(wreq.addr, `GDSL_OFF_MODE_NS)) begin
            mode_ns <= wreq.data[`GDSL_MODE_BIT];
         end else if (hit(wreq.addr, `GDSL_OFF_MODE_SEC)) begin
            mode_sec <= wreq.data[`GDSL_MODE_BIT];
         end
      end
   end

   // ****************************************
   // combined event outputs
   // ****************************************
   always_comb begin
      if (mode_ns) begin
         event_nonsecure = |(latch & ~pin_secure);
      end else begin
         event_nonsecure = |(pin_sense & ~pin_secure);
      end
      if (mode_sec) begin
         event_secure = |(latch & pin_secure);
      end else begin
         event_secure = |(pin_sense & pin_secure);
      end
   end

   // ****************************************
   // interrupt status and mask
   // ****************************************
   assign ev_rise = {event_secure & ~ev_sec_prev,
                     event_nonsecure & ~ev_ns_prev};
   assign stat_clr = (wr_do && wreq.strb[0] &&
      hit(wreq.addr, `GDSL_OFF_IRQ_STAT)) ? wreq.data[1:0] : 2'h0;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ev_ns_prev <= 1'b0;
         ev_sec_prev <= 1'b0;
      end else begin
         ev_ns_prev <= event_nonsecure;
         ev_sec_prev <= event_secure;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat <= `GDSL_RST_IRQ;
      end else begin
         irq_stat <= (irq_stat & ~stat_clr) | ev_rise;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask <= `GDSL_RST_IRQ;
      end else if (wr_do && wreq.strb[0] &&
                   hit(wreq.addr, `GDSL_OFF_IRQ_MASK)) begin
         irq_mask <= wreq.data[1:0];
      end
   end

   assign irq = |(irq_stat & irq_mask);

   // ****************************************
   // read channel
   // ****************************************
   always_comb begin
      rd_val = 32'h0000_0000;
      if (hit(s_axi_araddr, `GDSL_OFF_DIR)) begin
         rd_val = dir;
      end else if (hit(s_axi_araddr, `GDSL_OFF_DIRECTION_SET) ||
                   hit(s_axi_araddr, `GDSL_OFF_DIRECTION_CLEAR)) begin
         rd_val = dir;
      end else if (hit(s_axi_araddr, `GDSL_OFF_LATCH)) begin
         rd_val = latch;
      end else if (hit(s_axi_araddr, `GDSL_OFF_MODE_NS)) begin
         rd_val = {31'h0, mode_ns};
      end else if (hit(s_axi_araddr, `GDSL_OFF_MODE_SEC)) begin
         rd_val = {31'h0, mode_sec};
      end else if (hit(s_axi_araddr, `GDSL_OFF_IRQ_STAT)) begin
         rd_val = {30'h0, irq_stat};
      end else if (hit(s_axi_araddr, `GDSL_OFF_IRQ_MASK)) begin
         rd_val = {30'h0, irq_mask};
      end
   end

   assign s_axi_arready = (rstate == GDSL_RS_IDLE);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstate <= GDSL_RS_IDLE;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `GDSL_RESP_OKAY;
      end else begin
         case (rstate)
            GDSL_RS_IDLE: begin
               if (s_axi_arvalid) begin
                  rstate <= GDSL_RS_DATA;
                  s_axi_rvalid <= 1'b1;
                  s_axi_rdata <= rd_val;
                  s_axi_rresp <= mapped(s_axi_araddr) ? `GDSL_RESP_OKAY :
                     `GDSL_RESP_SLVERR;
               end
            end
            default: begin
               if (s_axi_rready) begin
                  rstate <= GDSL_RS_IDLE;
                  s_axi_rvalid <= 1'b0;
               end
            end
         endcase
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   logic quiet_cfg;
   assign quiet_cfg = (cfg_dir_wr.en == 32'h0000_0000);

   sequence s_wr_both;
      wr_do;
   endsequence

   sequence s_resp_held;
      s_axi_bvalid && (wstate == GDSL_WS_RESP);
   endsequence

   a_write_resp_due: assert property (
      s_wr_both |=> s_resp_held)
      else $error("no write response after the write");

   a_direction_set_orpin: assert property (
      (wr_do && hit(wreq.addr, `GDSL_OFF_DIRECTION_SET) && quiet_cfg) |=>
      dir == ($past(dir) | $past(wr_d)))
      else $error("direction set alias wrong");

   a_direction_clear_andpin: assert property (
      (wr_do && hit(wreq.addr, `GDSL_OFF_DIRECTION_CLEAR) && quiet_cfg) |=>
      dir == ($past(dir) & ~$past(wr_d)))
      else $error("direction clear alias wrong");

   a_alias_read_dir: assert property (
      (s_axi_arvalid && s_axi_arready &&
       hit(s_axi_araddr, `GDSL_OFF_DIRECTION_CLEAR)) |=>
      s_axi_rvalid && s_axi_rdata == $past(dir))
      else $error("alias read not direction");

   a_cfg_dir_shared: assert property (
      (!wr_do && cfg_dir_wr.en != 32'h0000_0000) |=>
      ((dir & $past(cfg_dir_wr.en)) ==
       ($past(cfg_dir_wr.val) & $past(cfg_dir_wr.en))))
      else $error("pin setup direction not shared");

   a_latch_catches: assert property (
      (pin_sense != 32'h0000_0000) |=>
      ((latch & $past(pin_sense)) == $past(pin_sense)))
      else $error("sense hit not latched");

   a_direct_nonsec: assert property (
      !mode_ns |-> event_nonsecure == |(pin_sense & ~pin_secure))
      else $error("direct non-secure event wrong");

   a_latched_sec: assert property (
      mode_sec |-> event_secure == |(latch & pin_secure))
      else $error("latched secure event wrong");

   a_latched_holds: assert property (
      (mode_ns && |(latch & ~pin_secure) && !wr_do) |=>
      (event_nonsecure || !$stable(pin_secure)))
      else $error("latched event dropped while latch set");

   a_mode_ns_wr: assert property (
      (wr_do && wreq.strb[0] && hit(wreq.addr, `GDSL_OFF_MODE_NS)) |=>
      mode_ns == $past(wreq.data[0]) && $stable(mode_sec))
      else $error("non-secure selector write wrong");

   a_mode_sec_wr: assert property (
      (wr_do && wreq.strb[0] && hit(wreq.addr, `GDSL_OFF_MODE_SEC)) |=>
      mode_sec == $past(wreq.data[0]) && $stable(mode_ns))
      else $error("secure selector write wrong");

   a_dir_bits_out: assert property (
      (wr_do && hit(wreq.addr, `GDSL_OFF_DIR) && wreq.strb == 4'hf &&
       quiet_cfg) |=> pin_dir == $past(wreq.data))
      else $error("pin direction output differs");

   a_dir_retained: assert property (
      (!wr_do && quiet_cfg) |=> $stable(dir))
      else $error("direction changed without a write");

endmodule

// File: shared/gdsl_params.svh
// Purpose: offsets, field positions, reset values of the direction and
//          sense latch block
// Assumes: byte addresses on a 32-bit register bus
// Notes:   definitions only
`ifndef GDSL_PARAMS_SVH
`define GDSL_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define GDSL_OFF_DIR 12'h014
`define GDSL_OFF_DIRECTION_SET 12'h018
`define GDSL_OFF_DIRECTION_CLEAR 12'h01c
`define GDSL_OFF_LATCH 12'h020
`define GDSL_OFF_MODE_NS 12'h024
`define GDSL_OFF_MODE_SEC 12'h028
`define GDSL_OFF_IRQ_STAT 12'h030
`define GDSL_OFF_IRQ_MASK 12'h034

// ****************************************
// fields and reset values
// ****************************************
`define GDSL_MODE_BIT 0
`define GDSL_IRQ_NS_BIT 0
`define GDSL_IRQ_SEC_BIT 1
`define GDSL_RST_DIR 32'h0000_0000
`define GDSL_RST_LATCH 32'h0000_0000
`define GDSL_RST_MODE 1'h0
`define GDSL_RST_IRQ 2'h0
`define GDSL_SENSE_OFF 2'h0
`define GDSL_SENSE_HIGH 2'h2
`define GDSL_SENSE_LOW 2'h3
`define GDSL_RESP_OKAY 2'h0
`define GDSL_RESP_SLVERR 2'h2

`endif

// File: shared/gdsl_pkg.sv
// Purpose: types shared by the direction and sense latch block
// Assumes: 32 pins
// Notes:   constants live in gdsl_params.svh
package gdsl_pkg;

   // ****************************************
   // bus channel states, gray ordered
   // ****************************************
   typedef enum logic [1:0] {
      GDSL_WS_IDLE = 2'h0,
      GDSL_WS_RESP = 2'h1
   } gdsl_wstate_t;

   typedef enum logic [1:0] {
      GDSL_RS_IDLE = 2'h0,
      GDSL_RS_DATA = 2'h1
   } gdsl_rstate_t;

   // ****************************************
   // held write request
   // ****************************************
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } gdsl_wreq_t;

   // ****************************************
   // per-pin alias write from the pin setup registers
   // ****************************************
   typedef struct packed {
      logic [31:0] en;
      logic [31:0] val;
   } gdsl_cfg_dir_t;

endpackage

// File: sim/tb_top.sv
// Purpose: self-checking bench for the direction and sense latch block
// Assumes: bus waits bounded at 50 cycles; seed fixed
// Notes:   design assertions live in the design files
`timescale 1ns/10ps
`include "gdsl_params.svh"
module tb_top
   import gdsl_pkg::*;
;
   logic core_clk, rst_n;
   logic [11:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic [31:0] pin_level, pin_secure, pin_dir, pin_sense, d, v, p, s;
   logic [63:0] sense_setup;
   gdsl_cfg_dir_t cfg_dir_wr;
   logic event_nonsecure, event_secure, irq;
   logic [31:0] exp_dir;
   int n_mismatch, n_compared, k;

   gdsl_top gdsl_top_inst (.core_clk(core_clk), .rst_n(rst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .pin_level(pin_level),
      .sense_setup(sense_setup), .pin_secure(pin_secure),
      .cfg_dir_wr(cfg_dir_wr), .pin_dir(pin_dir), .pin_sense(pin_sense),
      .event_nonsecure(event_nonsecure), .event_secure(event_secure),
      .irq(irq));

   // ****************************************
   // clock
   // ****************************************
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // ****************************************
   // reporting
   // ****************************************
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string msg);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen,
                  exp);
      end
   endtask

   task automatic hang(input string msg);
      n_mismatch++;
      $display("MISMATCH %0t %s wait ran out", $time, msg);
      end_of_test();
   endtask

   // ****************************************
   // bus master
   // ****************************************
   task automatic wr(input logic [11:0] a, input logic [31:0] dat);
      int i;
      bit b;
      b = 0;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= dat;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 50 && !b; i++) begin
         @(posedge core_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            r = bresp;
            b = 1;
            bready <= 1'b0;
         end
      end
      if (!b) hang("write");
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] dat);
      int i;
      bit b;
      b = 0;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 50 && !b; i++) begin
         @(posedge core_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            dat = rdata;
            r = rresp;
            b = 1;
            rready <= 1'b0;
         end
      end
      if (!b) hang("read");
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                         input string msg);
      logic [31:0] got;
      rd(a, got);
      chk(got, exp, msg);
   endtask

   function automatic logic [31:0] exp_sense(input logic [31:0] lv,
                                             input logic [63:0] ss);
      logic [31:0] o;
      o = '0;
      for (int i = 0; i < 32; i++) begin
         case (ss[2*i +: 2])
            `GDSL_SENSE_HIGH: o[i] = lv[i];
            `GDSL_SENSE_LOW: o[i] = ~lv[i];
            default: o[i] = 1'b0;
         endcase
      end
      return o;
   endfunction

   task automatic dir_all(input string msg);
      rd_chk(`GDSL_OFF_DIR, exp_dir, msg);
      rd_chk(`GDSL_OFF_DIRECTION_SET, exp_dir, msg);
      rd_chk(`GDSL_OFF_DIRECTION_CLEAR, exp_dir, msg);
      chk(pin_dir, exp_dir, "pin_dir port");
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      rst_n = 1'b0;
      {awaddr, araddr, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      pin_level = '0;
      sense_setup = '0;
      pin_secure = '0;
      cfg_dir_wr = '0;
      n_mismatch = 0;
      n_compared = 0;
      exp_dir = '0;
      void'($urandom(32'ha156a669));
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      // reset values of direction, latch and both mode registers
      dir_all("reset dir");
      rd_chk(`GDSL_OFF_LATCH, 32'h0, "reset latch");
      rd_chk(`GDSL_OFF_MODE_NS, 32'h0, "reset ns mode");
      rd_chk(`GDSL_OFF_MODE_SEC, 32'h0, "reset sec mode");
      $display("test reset done");
      // direct writes, then set and clear aliases with corners first
      for (k = 0; k < 6; k++) begin
         d = (k == 0) ? 32'hffff_ffff : $urandom();
         v = (k == 1) ? 32'h8000_0001 : $urandom();
         wr(`GDSL_OFF_DIR, d);
         chk(r, `GDSL_RESP_OKAY, "mapped write resp");
         exp_dir = d;
         dir_all("dir write");
         wr(`GDSL_OFF_DIRECTION_SET, v);
         exp_dir = exp_dir | v;
         dir_all("set alias");
         v = (k == 0) ? 32'h0000_0000 : $urandom();
         wr(`GDSL_OFF_DIRECTION_CLEAR, v);
         exp_dir = exp_dir & ~v;
         dir_all("clear alias");
         // pin setup alias pulse shares the same storage
         @(posedge core_clk);
         cfg_dir_wr <= '{en: $urandom(), val: $urandom()};
         @(posedge core_clk);
         exp_dir = (exp_dir & ~cfg_dir_wr.en) |
                   (cfg_dir_wr.val & cfg_dir_wr.en);
         cfg_dir_wr <= '0;
         dir_all("pin setup alias");
      end
      $display("test direction done");
      // unmapped place
      wr(12'h040, 32'hffff_ffff);
      chk(r, `GDSL_RESP_SLVERR, "unmapped write resp");
      rd_chk(12'h040, 32'h0, "unmapped read data");
      chk(r, `GDSL_RESP_SLVERR, "unmapped read resp");
      dir_all("dir after unmapped");
      // direct event style, every sense code
      for (k = 0; k < 24; k++) begin
         @(posedge core_clk);
         p = $urandom();
         s = (k < 4) ? 32'h0 : $urandom();
         sense_setup <= (k < 4) ? {32{k[1:0]}} : {$urandom(), $urandom()};
         pin_level <= p;
         pin_secure <= s;
         @(negedge core_clk);
         v = exp_sense(p, sense_setup);
         chk(pin_sense, v, "sense code");
         chk(event_nonsecure, |(v & ~s), "ns direct");
         chk(event_secure, |(v & s), "sec direct");
      end
      $display("test direct done");
      // latched style for both domains, independent selectors
      wr(`GDSL_OFF_MODE_NS, 32'h1);
      rd_chk(`GDSL_OFF_MODE_NS, 32'h1, "ns mode");
      rd_chk(`GDSL_OFF_MODE_SEC, 32'h0, "sec mode apart");
      wr(`GDSL_OFF_MODE_SEC, 32'h1);
      rd_chk(`GDSL_OFF_MODE_SEC, 32'h1, "sec mode");
      @(posedge core_clk);
      sense_setup <= {32{`GDSL_SENSE_HIGH}};
      pin_level <= '0;
      wr(`GDSL_OFF_LATCH, 32'hffff_ffff);
      rd_chk(`GDSL_OFF_LATCH, 32'h0, "latch cleared");
      p = $urandom() | 32'h0000_0101;
      s = 32'h0000_00ff;
      @(posedge core_clk);
      pin_level <= p;
      pin_secure <= s;
      @(posedge core_clk);
      pin_level <= '0;
      rd_chk(`GDSL_OFF_LATCH, p, "latch record");
      chk(event_nonsecure, |(p & ~s), "ns latched");
      chk(event_secure, |(p & s), "sec latched");
      wr(`GDSL_OFF_LATCH, p & ~s);
      rd_chk(`GDSL_OFF_LATCH, p & s, "partial clear");
      chk(event_nonsecure, 32'h0, "ns after clear");
      chk(event_secure, 32'h1, "sec holds");
      wr(`GDSL_OFF_LATCH, p);
      chk(event_secure, 32'h0, "sec after clear");
      $display("test latched done");
      // interrupt: raise masked, unmask, clear
      wr(`GDSL_OFF_IRQ_STAT, 32'h3);
      wr(`GDSL_OFF_IRQ_MASK, 32'h0);
      @(posedge core_clk);
      pin_level <= 32'h0000_0100;
      @(posedge core_clk);
      pin_level <= '0;
      rd_chk(`GDSL_OFF_IRQ_STAT, 32'h1, "irq status ns");
      chk(irq, 32'h0, "irq masked");
      wr(`GDSL_OFF_IRQ_MASK, 32'h1);
      chk(irq, 32'h1, "irq unmasked");
      wr(`GDSL_OFF_LATCH, 32'hffff_ffff);
      wr(`GDSL_OFF_IRQ_STAT, 32'h1);
      chk(irq, 32'h0, "irq cleared");
      rd_chk(`GDSL_OFF_IRQ_STAT, 32'h0, "irq status clear");
      $display("test interrupt done");
      end_of_test();
   end
endmodule
